// ---- include/scg_pkg.sv ----
package scg_pkg;

   // Display-list word layout: two flag bits above four 7-bit codes.
   localparam int WORD_W       = 30;
   localparam int CODE_W       = 7;
   localparam int CODES_PER_WD = 4;
   localparam int ADDR_W       = 15;
   localparam int COORD_W      = 10;
   localparam int SCOPES       = 4;
   localparam int EOL_BIT      = 29;
   localparam int EOL_INT_BIT  = 28;

   // Glyph repertoire windows.
   localparam logic [6:0] GLYPH_LO     = 7'h20;
   localparam logic [6:0] GLYPH_HI     = 7'h5F;
   localparam logic [6:0] EXT_GLYPH_LO = 7'h60;
   localparam logic [6:0] EXT_GLYPH_HI = 7'h7F;

   // The twelve control codes.
   localparam logic [6:0] CC_LF       = 7'h0A;
   localparam logic [6:0] CC_CR       = 7'h0D;
   localparam logic [6:0] CC_ITAL_ON  = 7'h0E;
   localparam logic [6:0] CC_ITAL_OFF = 7'h0F;
   localparam logic [6:0] CC_SIZE1    = 7'h11;
   localparam logic [6:0] CC_SIZE2    = 7'h12;
   localparam logic [6:0] CC_SIZE3    = 7'h13;
   localparam logic [6:0] CC_BRT1     = 7'h14;
   localparam logic [6:0] CC_BRT2     = 7'h15;
   localparam logic [6:0] CC_BRT3     = 7'h16;
   localparam logic [6:0] CC_SUPER    = 7'h1C;
   localparam logic [6:0] CC_SUB      = 7'h1D;

   // Grid pitches in scope units (about 100 units per inch).
   localparam logic [9:0] ADV_SIZE1  = 10'h00C;
   localparam logic [9:0] ADV_SIZE2  = 10'h011;
   localparam logic [9:0] ADV_SIZE3  = 10'h01D;
   localparam logic [9:0] LINE_SIZE1 = 10'h021;
   localparam logic [9:0] LINE_SIZE2 = 10'h032;
   localparam logic [9:0] LINE_SIZE3 = 10'h058;

   // Reset attributes.
   localparam logic [1:0] SIZE_RST   = 2'h1;
   localparam logic [1:0] BRT_RST    = 2'h2;
   localparam logic [9:0] COORD_RST  = 10'h000;

   // Host word transfer cost, used by the memory model to pace its slow answers.
   localparam int XFER_NS     = 5500;
   localparam int MCLK_NS     = 50;
   localparam int XFER_CYCLES = XFER_NS / MCLK_NS;

   typedef enum logic [3:0] {
      SCG_OP_NOP, SCG_OP_GLYPH, SCG_OP_LF, SCG_OP_CR, SCG_OP_SUPER, SCG_OP_SUB,
      SCG_OP_SIZE, SCG_OP_BRT, SCG_OP_ITAL_ON, SCG_OP_ITAL_OFF
   } scg_op_t;

   typedef struct packed {
      logic [9:0] x;
      logic [9:0] y;
   } scg_pos_t;

   typedef struct packed {
      logic [1:0] size;
      logic [1:0] bright;
      logic       italic;
   } scg_attr_t;

   typedef struct packed {
      logic [6:0] code;
      scg_pos_t   pos;
      scg_attr_t  attr;
   } scg_glyph_t;

endpackage

// ---- rtl/scg_code_decode.sv ----
`timescale 1ns/1ps
module scg_code_decode #(
   parameter logic EXT_GLYPHS = 1'b0
) (
   // Code in.
   input  wire logic [6:0]      code,
   // Classified operation and its argument.
   output scg_pkg::scg_op_t     op,
   output logic       [1:0]     arg
);

   // Classify one code; unknown control codes and absent glyphs do nothing.
   always_comb begin
      op  = scg_pkg::SCG_OP_NOP;
      arg = 2'h0;
      if (code >= scg_pkg::GLYPH_LO && code <= scg_pkg::GLYPH_HI) begin
         op = scg_pkg::SCG_OP_GLYPH;
      end else if (code >= scg_pkg::EXT_GLYPH_LO && EXT_GLYPHS) begin
         op = scg_pkg::SCG_OP_GLYPH;
      end else begin
         case (code)
            scg_pkg::CC_LF:       op = scg_pkg::SCG_OP_LF;
            scg_pkg::CC_CR:       op = scg_pkg::SCG_OP_CR;
            scg_pkg::CC_SUPER:    op = scg_pkg::SCG_OP_SUPER;
            scg_pkg::CC_SUB:      op = scg_pkg::SCG_OP_SUB;
            scg_pkg::CC_ITAL_ON:  op = scg_pkg::SCG_OP_ITAL_ON;
            scg_pkg::CC_ITAL_OFF: op = scg_pkg::SCG_OP_ITAL_OFF;
            scg_pkg::CC_SIZE1: begin
               op  = scg_pkg::SCG_OP_SIZE;
               arg = 2'h1;
            end
            scg_pkg::CC_SIZE2: begin
               op  = scg_pkg::SCG_OP_SIZE;
               arg = 2'h2;
            end
            scg_pkg::CC_SIZE3: begin
               op  = scg_pkg::SCG_OP_SIZE;
               arg = 2'h3;
            end
            scg_pkg::CC_BRT1: begin
               op  = scg_pkg::SCG_OP_BRT;
               arg = 2'h1;
            end
            scg_pkg::CC_BRT2: begin
               op  = scg_pkg::SCG_OP_BRT;
               arg = 2'h2;
            end
            scg_pkg::CC_BRT3: begin
               op  = scg_pkg::SCG_OP_BRT;
               arg = 2'h3;
            end
            default: op = scg_pkg::SCG_OP_NOP;
         endcase
      end
   end

endmodule

// ---- rtl/scg_list_proc.sv ----
`timescale 1ns/1ps
// What this block does
// - Draws 64 printable codes 20h to 5Fh as stroked glyphs.
// - Build option adds 32 more glyph codes 60h to 7Fh, 96 in all.
// - Twelve control codes position, size, brighten, italicise and format text.
// - Each glyph lands right of the previous one, like a typewriter.
// - Each fetched word is 30 bits holding four packed 7-bit codes.
// - All four codes finish before the next word is requested.
// - After start, words are fetched alone from addresses counting up by one.
// - End-of-list word returns control by interrupt or silent halt, per its bit.
// - Origin is explicit x and/or y, optionally offset by the vector beam.
// - The block signals the host on a single priority interrupt channel.
// - Host talks through one destination code and two control bits.
// - Output drives up to four display scopes.
// - One control code switches italics on.
// - Three glyph sizes, each chosen by a control code.
// - Three brightness levels, each chosen by a control code.
// - Line feed, carriage return, superscript raise and subscript lower.
// - Horizontal advance is automatic with a step set by glyph size.
// - Code-only positioning stays on a size-pitched grid anchored at the origin.
module scg_list_proc #(
   parameter logic EXT_GLYPHS = 1'b0
) (
   // Clock and reset.
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // Host destination write and interface control bits.
   input  wire logic                 generator_destination_code,
   input  wire logic [29:0]          dest_data,
   input  wire logic [1:0]           interface_control_bits,
   input  wire logic                 org_set_x,
   input  wire logic                 org_set_y,
   input  scg_pkg::scg_pos_t         org_pos,
   input  scg_pkg::scg_pos_t         beam_pos,
   // Memory word fetch.
   output logic                      mem_req_q,
   output logic [14:0]               mem_addr_q,
   input  wire logic                 mem_ack,
   input  wire logic [29:0]          mem_data,
   // Priority interrupt channel.
   output logic                      priority_interrupt_channel_q,
   output logic                      busy_q,
   input  wire logic                 int_ack,
   // Stroke generator and scopes.
   output logic                      glyph_go_q,
   output scg_pkg::scg_glyph_t       glyph_q,
   input  wire logic                 glyph_done,
   input  wire logic [3:0]           scope_sel,
   output logic [3:0]                scope_en_q
);

   typedef enum logic [2:0] {
      SCG_IDLE, SCG_FETCH, SCG_DECODE, SCG_DRAW, SCG_NEXT
   } scg_state_t;

   scg_state_t          state_q;
   logic [29:0]         word_q;
   logic [1:0]          slot_q;
   scg_pkg::scg_pos_t   pos_q;
   scg_pkg::scg_pos_t   anchor_q;
   scg_pkg::scg_attr_t  attr_q;
   logic                first_q;
   logic [6:0]          code_cur;
   scg_pkg::scg_op_t    op_cur;
   logic [1:0]          arg_cur;
   logic                start;
   logic                last_slot;
   logic                eol_word;

   // Horizontal step for a glyph size.
   function automatic logic [9:0] adv_step(input logic [1:0] size);
      case (size)
         2'h2:    adv_step = scg_pkg::ADV_SIZE2;
         2'h3:    adv_step = scg_pkg::ADV_SIZE3;
         default: adv_step = scg_pkg::ADV_SIZE1;
      endcase
   endfunction

   // Line pitch for a glyph size.
   function automatic logic [9:0] line_step(input logic [1:0] size);
      case (size)
         2'h2:    line_step = scg_pkg::LINE_SIZE2;
         2'h3:    line_step = scg_pkg::LINE_SIZE3;
         default: line_step = scg_pkg::LINE_SIZE1;
      endcase
   endfunction

   // Half a line pitch, used to raise or lower text for scripts.
   function automatic logic [9:0] half_step(input logic [1:0] size);
      half_step = line_step(size) >> 1;
   endfunction

   // Pick one 7-bit group from the word; slot 0 is the most significant.
   function automatic logic [6:0] code_at(input logic [29:0] w, input logic [1:0] s);
      case (s)
         2'h0:    code_at = w[27:21];
         2'h1:    code_at = w[20:14];
         2'h2:    code_at = w[13:7];
         default: code_at = w[6:0];
      endcase
   endfunction

   // A new list starts on a destination write with the run bit set.
   assign start     = generator_destination_code & interface_control_bits[0];
   assign code_cur  = code_at(word_q, slot_q);
   assign last_slot = (slot_q == 2'(scg_pkg::CODES_PER_WD - 1));
   assign eol_word  = word_q[scg_pkg::EOL_BIT];

   scg_code_decode #(
      .EXT_GLYPHS (EXT_GLYPHS)
   ) u_decode (
      .code (code_cur),
      .op   (op_cur),
      .arg  (arg_cur)
   );

   // Sequencer. A start while busy is ignored so an active list is never torn.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= SCG_IDLE;
      end else begin
         case (state_q)
            SCG_IDLE: begin
               if (start) begin
                  state_q <= SCG_FETCH;
               end
            end
            SCG_FETCH: begin
               if (mem_ack) begin
                  state_q <= SCG_DECODE;
               end
            end
            SCG_DECODE: begin
               if (eol_word) begin
                  state_q <= SCG_IDLE;
               end else if (op_cur == scg_pkg::SCG_OP_GLYPH) begin
                  state_q <= SCG_DRAW;
               end else begin
                  state_q <= SCG_NEXT;
               end
            end
            SCG_DRAW: begin
               if (glyph_done) begin
                  state_q <= SCG_NEXT;
               end
            end
            SCG_NEXT: begin
               if (last_slot) begin
                  state_q <= SCG_FETCH;
               end else begin
                  state_q <= SCG_DECODE;
               end
            end
            default: state_q <= SCG_IDLE;
         endcase
      end
   end

   // Slot counter walks the four codes of the held word.
   always_ff @(posedge mclk) begin
      if (rst) begin
         slot_q <= 2'h0;
      end else if (state_q == SCG_FETCH) begin
         slot_q <= 2'h0;
      end else if (state_q == SCG_NEXT) begin
         slot_q <= slot_q + 2'h1;
      end
   end

   // Word fetch: the request stands until the memory answers.
   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_req_q <= 1'b0;
         word_q    <= 30'h0000_0000;
      end else begin
         if (mem_req_q && mem_ack) begin
            mem_req_q <= 1'b0;
            word_q    <= mem_data;
         end else if ((state_q == SCG_IDLE && start)
                      || (state_q == SCG_NEXT && last_slot)) begin
            mem_req_q <= 1'b1;
         end
      end
   end

   // Address loads from the host, then counts up after every accepted word.
   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_addr_q <= 15'h0000;
      end else if (state_q == SCG_IDLE && start) begin
         mem_addr_q <= dest_data[14:0];
      end else if (mem_req_q && mem_ack) begin
         mem_addr_q <= mem_addr_q + 15'h0001;
      end
   end

   // Busy flag tells the host a list is running.
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else if (state_q == SCG_IDLE) begin
         busy_q <= start;
      end else if (state_q == SCG_DECODE && eol_word) begin
         busy_q <= 1'b0;
      end
   end

   // Interrupt request: set by an end word that asks for it, cleared by the
   // host acknowledge. Set wins so a new end word is never lost.
   always_ff @(posedge mclk) begin
      if (rst) begin
         priority_interrupt_channel_q <= 1'b0;
      end else if (state_q == SCG_DECODE && eol_word && word_q[scg_pkg::EOL_INT_BIT]) begin
         priority_interrupt_channel_q <= 1'b1;
      end else if (int_ack) begin
         priority_interrupt_channel_q <= 1'b0;
      end
   end

   // Attributes: size, brightness and italics stay until changed.
   always_ff @(posedge mclk) begin
      if (rst) begin
         attr_q.size   <= scg_pkg::SIZE_RST;
         attr_q.bright <= scg_pkg::BRT_RST;
         attr_q.italic <= 1'b0;
      end else if (state_q == SCG_DECODE && !eol_word) begin
         case (op_cur)
            scg_pkg::SCG_OP_SIZE:     attr_q.size   <= arg_cur;
            scg_pkg::SCG_OP_BRT:      attr_q.bright <= arg_cur;
            scg_pkg::SCG_OP_ITAL_ON:  attr_q.italic <= 1'b1;
            scg_pkg::SCG_OP_ITAL_OFF: attr_q.italic <= 1'b0;
            default:                  attr_q        <= attr_q;
         endcase
      end
   end

   // Anchor is the top-left of the list; explicit x and/or y, plus the beam
   // position when the relative bit is set. Unset axes keep their last value unless that bit is set, when they take the beam position alone.
   always_ff @(posedge mclk) begin
      if (rst) begin
         anchor_q.x <= scg_pkg::COORD_RST;
         anchor_q.y <= scg_pkg::COORD_RST;
      end else if (state_q == SCG_IDLE && start) begin
         if (interface_control_bits[1]) begin
            anchor_q.x <= (org_set_x ? org_pos.x : 10'h000) + beam_pos.x;
            anchor_q.y <= (org_set_y ? org_pos.y : 10'h000) + beam_pos.y;
         end else begin
            if (org_set_x) begin
               anchor_q.x <= org_pos.x;
            end
            if (org_set_y) begin
               anchor_q.y <= org_pos.y;
            end
         end
      end
   end

   // Pen position. Codes move it only in size-pitched steps from the anchor,
   // so the grid follows wherever the vector generator put the anchor.
   always_ff @(posedge mclk) begin
      if (rst) begin
         pos_q.x <= scg_pkg::COORD_RST;
         pos_q.y <= scg_pkg::COORD_RST;
      end else if (state_q == SCG_FETCH && first_q) begin
         pos_q <= anchor_q;
      end else if (state_q == SCG_DRAW && glyph_done) begin
         pos_q.x <= pos_q.x + adv_step(attr_q.size);
      end else if (state_q == SCG_DECODE && !eol_word) begin
         case (op_cur)
            scg_pkg::SCG_OP_CR: begin
               pos_q.x <= anchor_q.x;
            end
            scg_pkg::SCG_OP_LF: begin
               pos_q.y <= pos_q.y + line_step(attr_q.size);
            end
            scg_pkg::SCG_OP_SUPER: begin
               pos_q.y <= pos_q.y - half_step(attr_q.size);
            end
            scg_pkg::SCG_OP_SUB: begin
               pos_q.y <= pos_q.y + half_step(attr_q.size);
            end
            default: pos_q <= pos_q;
         endcase
      end
   end

   // First-fetch marker. The pen takes the anchor only on the first fetch of a
   // list, one cycle after the anchor register has been loaded, so later
   // fetches of the same list never pull the pen back to the origin.
   always_ff @(posedge mclk) begin
      if (rst) begin
         first_q <= 1'b0;
      end else if (state_q == SCG_IDLE && start) begin
         first_q <= 1'b1;
      end else if (state_q == SCG_FETCH) begin
         first_q <= 1'b0;
      end
   end

   // Glyph request toward the stroke generator.
   always_ff @(posedge mclk) begin
      if (rst) begin
         glyph_go_q <= 1'b0;
         glyph_q    <= '0;
      end else begin
         glyph_go_q <= 1'b0;
         if (state_q == SCG_DECODE && !eol_word && op_cur == scg_pkg::SCG_OP_GLYPH) begin
            glyph_go_q    <= 1'b1;
            glyph_q.code  <= code_cur;
            glyph_q.pos   <= pos_q;
            glyph_q.attr  <= attr_q;
         end
      end
   end

   // Scope unblank enables follow the host selection while a list runs.
   always_ff @(posedge mclk) begin
      if (rst) begin
         scope_en_q <= 4'h0;
      end else begin
         scope_en_q <= busy_q ? scope_sel : 4'h0;
      end
   end

endmodule

// ---- sim/scg_list_proc_chk.sv ----
`timescale 1ns/1ps
module scg_list_proc_chk (
   // Clock and reset.
   input logic        mclk,
   input logic        rst,
   // Host side.
   input logic        generator_destination_code,
   input logic [29:0] dest_data,
   input logic [1:0]  interface_control_bits,
   input logic        priority_interrupt_channel_q,
   input logic        busy_q,
   input logic        int_ack,
   // Memory side.
   input logic        mem_req_q,
   input logic [14:0] mem_addr_q,
   input logic        mem_ack,
   input logic [29:0] mem_data,
   // Stroke side.
   input logic        glyph_go_q,
   input logic [3:0]  scope_sel,
   input logic [3:0]  scope_en_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // A word is taken only when request and answer meet on one edge.
   wire       take       = mem_req_q && mem_ack;
   wire [14:0] start_addr = dest_data[14:0];
   // Four codes need at least two cycles each, so the bus stays quiet that long.
   sequence four_codes_s;
      !mem_req_q [*7];
   endsequence
   sequence end_word_s;
      take && mem_data[29];
   endsequence
   start_a: assert property (
      generator_destination_code && interface_control_bits[0] && !busy_q
      |=> busy_q && mem_req_q && mem_addr_q == $past(start_addr)) else $error("start missed");
   req_hold_a: assert property (
      mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q)) else $error("request dropped");
   addr_step_a: assert property (
      take && !mem_data[29] |=> mem_addr_q == $past(mem_addr_q) + 15'h0001)
      else $error("address not stepped");
   four_codes_a: assert property (
      take && !mem_data[29] |=> four_codes_s) else $error("early fetch");
   end_busy_a: assert property (
      end_word_s |-> ##[1:3] !busy_q) else $error("busy kept after end");
   end_int_a: assert property (
      (end_word_s and mem_data[28]) |-> ##[1:4] priority_interrupt_channel_q)
      else $error("no end interrupt");
   silent_end_a: assert property (
      (end_word_s and (!mem_data[28] && !priority_interrupt_channel_q))
      |=> !priority_interrupt_channel_q [*4]) else $error("interrupt on silent end");
   int_hold_a: assert property (
      priority_interrupt_channel_q && !int_ack |=> priority_interrupt_channel_q)
      else $error("interrupt lost");
   idle_quiet_a: assert property (
      !busy_q |-> !mem_req_q && !glyph_go_q) else $error("activity while idle");
   go_pulse_a: assert property (
      glyph_go_q |=> !glyph_go_q) else $error("glyph start too long");
   scope_follow_a: assert property (
      busy_q && $past(busy_q) |-> scope_en_q == $past(scope_sel)) else $error("scope enable");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst |=> !busy_q && !mem_req_q && !priority_interrupt_channel_q) else $error("reset");
endmodule

bind scg_list_proc scg_list_proc_chk u_chk (.mclk, .rst, .generator_destination_code,
   .dest_data, .interface_control_bits, .priority_interrupt_channel_q, .busy_q, .int_ack,
   .mem_req_q, .mem_addr_q, .mem_ack, .mem_data, .glyph_go_q, .scope_sel, .scope_en_q);

// ---- sim/scg_mem_model.sv ----
`timescale 1ns/1ps
module scg_mem_model (
   // Clock and reset.
   input  logic        mclk,
   input  logic        rst,
   // Word fetch side.
   input  logic        mem_req,
   input  logic [14:0] mem_addr,
   output logic        mem_ack,
   output logic [29:0] mem_data,
   // Stroke generator side.
   input  logic        glyph_go,
   output logic        glyph_done,
   // Pace and list image.
   input  logic        slow,
   input  logic [29:0] image [64]
);
   int mem_wait;
   int stroke_wait;
   // Memory answers at once, or after a host word transfer wait when slow; outside the answer the data lines toggle as junk.
   always_ff @(posedge mclk) begin
      mem_ack  <= 1'b0;
      mem_data <= ~mem_data;
      if (rst) begin
         mem_wait <= 0;
         mem_data <= 30'h2AAA_AAAA;
      end else if (mem_req && !mem_ack) begin
         if (mem_wait >= (slow ? scg_pkg::XFER_CYCLES : 0)) begin
            mem_ack  <= 1'b1;
            mem_data <= image[mem_addr[5:0]];
            mem_wait <= 0;
         end else begin
            mem_wait <= mem_wait + 1;
         end
      end
   end
   // The stroke generator reports a finished glyph after a short or long draw.
   always_ff @(posedge mclk) begin
      glyph_done <= 1'b0;
      if (rst) begin
         stroke_wait <= 0;
      end else if (glyph_go) begin
         stroke_wait <= slow ? 6 : 1;
      end else if (stroke_wait > 0) begin
         stroke_wait <= stroke_wait - 1;
         glyph_done  <= (stroke_wait == 1);
      end
   end
endmodule

// ---- sim/stroke_character_list_processor_bench.sv ----
`timescale 1ns/1ps
module stroke_character_list_processor_bench;
   logic                mclk;
   logic                rst;
   logic                generator_destination_code;
   logic [29:0]         dest_data;
   logic [1:0]          interface_control_bits;
   logic                org_set_x;
   logic                org_set_y;
   scg_pkg::scg_pos_t   org_pos;
   scg_pkg::scg_pos_t   beam_pos;
   logic                mem_req_q;
   logic [14:0]         mem_addr_q;
   logic                mem_ack;
   logic [29:0]         mem_data;
   logic                priority_interrupt_channel_q;
   logic                busy_q;
   logic                int_ack;
   logic                glyph_go_q;
   scg_pkg::scg_glyph_t glyph_q;
   logic                glyph_done;
   logic [3:0]          scope_sel;
   logic [3:0]          scope_en_q;
   logic                slow;
   logic [29:0]         image [64];
   int                  errors;
   int                  n_tests;
   int                  seed;
   scg_pkg::scg_glyph_t exp_q [$];
   logic [14:0]         addr_q [$];
   logic [9:0]          px;
   logic [9:0]          py;
   logic [9:0]          ax;
   logic [1:0]          sz;
   logic [1:0]          br;
   logic                it;
   logic [6:0]          ctl [12] = '{scg_pkg::CC_LF, scg_pkg::CC_CR, scg_pkg::CC_ITAL_ON,
      scg_pkg::CC_ITAL_OFF, scg_pkg::CC_SIZE1, scg_pkg::CC_SIZE2, scg_pkg::CC_SIZE3,
      scg_pkg::CC_BRT1, scg_pkg::CC_BRT2, scg_pkg::CC_BRT3, scg_pkg::CC_SUPER, scg_pkg::CC_SUB};

   scg_list_proc #(.EXT_GLYPHS(1'b1)) DUT (.mclk, .rst, .generator_destination_code, .dest_data,
      .interface_control_bits, .org_set_x, .org_set_y, .org_pos, .beam_pos, .mem_req_q,
      .mem_addr_q, .mem_ack, .mem_data, .priority_interrupt_channel_q, .busy_q, .int_ack,
      .glyph_go_q, .glyph_q, .glyph_done, .scope_sel, .scope_en_q);
   scg_mem_model u_far (.mclk, .rst, .mem_req(mem_req_q), .mem_addr(mem_addr_q), .mem_ack,
      .mem_data, .glyph_go(glyph_go_q), .glyph_done, .slow, .image);

   // Free-running system clock.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Grid pitch for a size; the line pitch is halved for raised and lowered text.
   function automatic logic [9:0] pitch(input logic [1:0] s, input bit line);
      case (s)
         2'h2: return line ? scg_pkg::LINE_SIZE2 : scg_pkg::ADV_SIZE2;
         2'h3: return line ? scg_pkg::LINE_SIZE3 : scg_pkg::ADV_SIZE3;
         default: return line ? scg_pkg::LINE_SIZE1 : scg_pkg::ADV_SIZE1;
      endcase
   endfunction

   // Reference pen: glyphs are queued with the attributes in force, controls move state.
   task automatic put_code(input logic [6:0] c);
      if (c >= scg_pkg::GLYPH_LO) begin
         exp_q.push_back({c, px, py, sz, br, it});
         px = px + pitch(sz, 0);
      end else begin
         case (c)
            scg_pkg::CC_LF: py = py + pitch(sz, 1);
            scg_pkg::CC_CR: px = ax;
            scg_pkg::CC_SUPER: py = py - (pitch(sz, 1) >> 1);
            scg_pkg::CC_SUB: py = py + (pitch(sz, 1) >> 1);
            scg_pkg::CC_ITAL_ON: it = 1'b1;
            scg_pkg::CC_ITAL_OFF: it = 1'b0;
            scg_pkg::CC_SIZE1, scg_pkg::CC_SIZE2, scg_pkg::CC_SIZE3: sz = 2'(c - 7'h10);
            scg_pkg::CC_BRT1, scg_pkg::CC_BRT2, scg_pkg::CC_BRT3: br = 2'(c - 7'h13);
            default: ;
         endcase
      end
   endtask

   // Builds a list, starts it, tries a start while busy, then checks the ending.
   task automatic do_list(input int base, input int n, input logic irq, input bit walk,
                          input logic [2:0] cfg);
      logic [31:0] r;
      logic [6:0]  c;
      logic [29:0] w;
      int          k;
      @(negedge mclk);
      r = $random(seed);
      {org_pos, beam_pos} = {r[19:0], r[31:12]};
      scope_sel = r[3:0];
      slow = cfg[2];
      interface_control_bits = {cfg[1], 1'b1};
      org_set_x = cfg[0];
      org_set_y = cfg[0] ^ cfg[1];
      ax = (org_set_x ? org_pos.x : 10'h000) + (cfg[1] ? beam_pos.x : 10'h000);
      px = ax;
      py = (org_set_y ? org_pos.y : 10'h000) + (cfg[1] ? beam_pos.y : 10'h000);
      for (int i = 0; i < n; i++) begin
         for (k = 0; k < 4; k++) begin
            r = $random(seed);
            c = r[0] ? ctl[r[4:1] % 12] : 7'h20 + 7'(r[11:5] % 96);
            if (walk && !k[0]) c = ctl[(2 * i + k / 2) % 12];
            w[27 - 7 * k -: 7] = c;
            put_code(c);
         end
         w[29:28] = 2'b00;
         image[base + i] = w;
         addr_q.push_back(15'(base + i));
      end
      image[base + n] = {1'b1, irq, r[27:0]};
      addr_q.push_back(15'(base + n));
      dest_data = {r[14:0], 15'(base)};
      generator_destination_code = 1'b1;
      @(negedge mclk);
      generator_destination_code = 1'b0;
      repeat (2) @(negedge mclk);
      dest_data = 30'h0000_0007;
      generator_destination_code = 1'b1;
      @(negedge mclk);
      generator_destination_code = 1'b0;
      for (k = 0; k < 20000 && busy_q !== 1'b0; k++) @(negedge mclk);
      if (busy_q !== 1'b0) begin
         errors++;
         report_and_stop();
      end
      check(32'(exp_q.size() + addr_q.size()), 32'h0000_0000);
      repeat (3) @(negedge mclk);
      check(32'(priority_interrupt_channel_q), 32'(irq));
      if (irq) begin
         int_ack = 1'b1;
         @(negedge mclk);
         int_ack = 1'b0;
         check(32'(priority_interrupt_channel_q), 32'h0000_0000);
      end
   endtask

   // Every glyph and every fetch is matched against the reference in issue order.
   always @(posedge mclk) begin
      if (!rst && glyph_go_q)
         check(glyph_q, exp_q.size() ? 32'(exp_q.pop_front()) : 32'hFFFF_FFFF);
      if (!rst && mem_req_q && mem_ack)
         check(32'(mem_addr_q), addr_q.size() ? 32'(addr_q.pop_front()) : 32'hFFFF_FFFF);
   end

   // Main sequence: reset, three lists of differing origin and pace, one refused start.
   initial begin
      seed = 32'h585f;
      errors = 0;
      n_tests = 0;
      rst = 1'b1;
      generator_destination_code = 1'b0;
      dest_data = 30'h0000_0000;
      interface_control_bits = 2'b00;
      org_set_x = 1'b0;
      org_set_y = 1'b0;
      org_pos = '0;
      beam_pos = '0;
      int_ack = 1'b0;
      scope_sel = 4'h0;
      slow = 1'b0;
      sz = scg_pkg::SIZE_RST;
      br = scg_pkg::BRT_RST;
      it = 1'b0;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      check(32'({busy_q, mem_req_q, priority_interrupt_channel_q, scope_en_q}), 32'h0);
      do_list(2, 6, 1'b1, 1'b1, 3'b001);
      do_list(20, 8, 1'b0, 1'b0, 3'b110);
      interface_control_bits = 2'b00;
      dest_data = 30'h0000_0028;
      generator_destination_code = 1'b1;
      @(negedge mclk);
      generator_destination_code = 1'b0;
      repeat (3) @(negedge mclk);
      check(32'({busy_q, mem_req_q}), 32'h0000_0000);
      do_list(40, 5, 1'b1, 1'b0, 3'b011);
      report_and_stop();
   end
endmodule
